// [hw/flash_guard_map.vh]
`ifndef FLASH_GUARD_MAP_VH
`define FLASH_GUARD_MAP_VH
// =====================================================================
// Register byte addresses
`define OFS_MODE_ENTRY      6'h00
`define OFS_DATA_CTL        6'h04
`define OFS_PE_MODE_CTL     6'h08
`define OFS_WB_ZERO         6'h0c
`define OFS_WB_ONE          6'h10
`define OFS_WB_HIGH         6'h14
`define OFS_WB_LOW          6'h18
`define OFS_COMMAND         6'h1c
`define OFS_STATUS          6'h20
`define OFS_WINDOW          6'h24
`define OFS_REJECT          6'h28
// =====================================================================
// Field positions and values
`define MODE_READ           16'h0000
`define DATA_CTL_OFF        8'h00
`define DATA_CTL_RST        8'h01
`define PE_MODE_RST         8'h00
`define BIT_DATA_EN         0
`define BIT_USER_PE_DIS     3
`define CMD_WINDOW_PROG     8'h01
`define CMD_STARTUP_PROG    8'h02
`define CMD_CYCLES          4'h4
`define WIN_RST_START       12'h000
`define WIN_RST_END         12'hfff
`define WB_RST              16'h0000
`define REJECT_RST          6'h00
`define CMD_LAST            4'h1
// =====================================================================
// Request operation codes
`define OP_READ             2'h0
`define OP_PROGRAM          2'h1
`define OP_ERASE            2'h2
// =====================================================================
// Reject reason bit positions
`define RJ_WINDOW           0
`define RJ_READ_MODE        1
`define RJ_DATA_DISABLE     2
`define RJ_USER_PE_DIS      3
`define RJ_DATA_EN          4
`define RJ_CMD              5
`endif

// [hw/flash_program_erase_guard.v]
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "flash_guard_map.vh"
module flash_program_erase_guard (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        nv_resetn,
    input  wire        variant_two,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [5:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        req_valid,
    input  wire [1:0]  req_op,
    input  wire        req_data_area,
    input  wire [21:0] req_addr,
    output reg         req_grant,
    output reg         req_reject,
    output reg         boot_alternate
);

    // =================================================================
    // Volatile control registers
    // Two reset domains: presetn clears these, while the extra-area
    // storage below answers only to nv_resetn, so a warm reset never
    // loses the window or the boot choice.
    reg [15:0] mode_entry_q;
    reg [7:0]  data_ctl_q;
    reg [7:0]  pe_mode_q;
    reg [15:0] wb_zero_q;
    reg [15:0] wb_one_q;
    reg [15:0] wb_high_q;
    reg [15:0] wb_low_q;
    reg [5:0]  reject_q;
    reg [31:0] rdata_q;
    reg        cmd_busy_q;
    reg        cmd_swap_q;
    reg [3:0]  cmd_cnt_q;
    // Staged bounds, copied from the buffers when a command issues
    reg [11:0] stage_start_q;
    reg [11:0] stage_end_q;
    reg        boot_taken_q;
    // Extra-area storage, cleared only at power-on
    reg [11:0] win_start_q;
    reg [11:0] win_end_q;
    reg        nv_swap_q;

    // Decoded strobes and guard terms
    wire       apb_wr;
    wire       apb_rd;
    wire       hit;
    wire       pe_mode;
    wire       data_en;
    wire       access_disable;
    wire       user_pe_dis;
    wire       cmd_write;
    wire       cmd_known;
    wire       cmd_block;
    wire       cmd_done;
    wire [11:0] blk;
    wire       in_window;
    reg  [5:0] why;
    reg  [31:0] rd_mux;

    // =================================================================
    // APB slave: zero wait state, error on unmapped addresses
    // Read data is registered in the setup cycle, so prdata already
    // stands in the access cycle and no wait state is needed
    assign pready  = 1'b1;
    assign apb_wr  = psel & penable & pwrite;
    assign apb_rd  = psel & penable & ~pwrite;
    assign hit     = (paddr == `OFS_MODE_ENTRY) | (paddr == `OFS_DATA_CTL) |
                     (paddr == `OFS_PE_MODE_CTL) | (paddr == `OFS_WB_ZERO) |
                     (paddr == `OFS_WB_ONE) | (paddr == `OFS_WB_HIGH) |
                     (paddr == `OFS_WB_LOW) | (paddr == `OFS_COMMAND) |
                     (paddr == `OFS_STATUS) | (paddr == `OFS_WINDOW) |
                     (paddr == `OFS_REJECT);
    assign pslverr = psel & penable & ~hit;
    assign prdata  = rdata_q;

    // =================================================================
    // Protection conditions, each evaluated on its own
    // Each term is kept separate so one guard never masks another
    // in the reject reasons
    assign pe_mode        = (mode_entry_q != `MODE_READ);
    assign data_en        = data_ctl_q[`BIT_DATA_EN];
    assign access_disable = ~pe_mode &
                            (data_ctl_q == `DATA_CTL_OFF);
    assign user_pe_dis    = pe_mode_q[`BIT_USER_PE_DIS];

    // Block index: variant one compares ten bits, variant two twelve
    assign blk = variant_two ? req_addr[21:10] :
                 {2'b00, req_addr[19:10]};
    // End bound is exclusive, so start equal to end means no window
    // Limitation: the top block index can never lie inside a programmed window,
    // because a programmed end bound cannot point past it
    assign in_window = (blk >= win_start_q) & (blk < win_end_q);

    // =================================================================
    // Reasons for refusing the present request
    // Several reasons may be set at once, so software sees every guard
    // that fired; user-area reads are never refused.
    always @* begin
        why = 6'h00;
        if (req_data_area) begin
            if (req_op != `OP_READ && !pe_mode)
                why[`RJ_READ_MODE] = 1'b1;
            if (access_disable)
                why[`RJ_DATA_DISABLE] = 1'b1;
            if (!data_en)
                why[`RJ_DATA_EN] = 1'b1;
        end else if (req_op != `OP_READ) begin
            if (!pe_mode)
                why[`RJ_READ_MODE] = 1'b1;
            if (access_disable)
                why[`RJ_DATA_DISABLE] = 1'b1;
            if (user_pe_dis)
                why[`RJ_USER_PE_DIS] = 1'b1;
            if (!in_window)
                why[`RJ_WINDOW] = 1'b1;
        end
    end

    // =================================================================
    // Extra-area commands via the command register
    assign cmd_write = apb_wr & (paddr == `OFS_COMMAND);
    // Unknown codes are dropped without a reject reason
    assign cmd_known = (pwdata[7:0] == `CMD_WINDOW_PROG) |
                       (pwdata[7:0] == `CMD_STARTUP_PROG);
    // Refused when idle check fails: read mode or data access disabled
    // A command while busy is refused, not queued, so the staged
    // bounds of the running command can never be overwritten
    assign cmd_block = ~pe_mode | ~data_en | cmd_busy_q;
    assign cmd_done  = cmd_busy_q & (cmd_cnt_q == `CMD_LAST);

    // Grant or reject, one cycle after the request
    // Exactly one of the two answers pulses for each request
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_grant  <= 1'b0;
            req_reject <= 1'b0;
        end else begin
            // Granted only with no reason set; nothing else moves
            req_grant  <= req_valid & (why == 6'h00);
            req_reject <= req_valid & (why != 6'h00);
        end
    end

    // Register writes and command sequencing
    // Writes to read-only or unmapped offsets fall through unchanged
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_entry_q  <= `MODE_READ;
            data_ctl_q    <= `DATA_CTL_RST;
            pe_mode_q     <= `PE_MODE_RST;
            wb_zero_q     <= `WB_RST;
            wb_one_q      <= `WB_RST;
            wb_high_q     <= `WB_RST;
            wb_low_q      <= `WB_RST;
            reject_q      <= `REJECT_RST;
            cmd_busy_q    <= 1'b0;
            cmd_swap_q    <= 1'b0;
            cmd_cnt_q     <= 4'h0;
            stage_start_q <= `WIN_RST_START;
            stage_end_q   <= `WIN_RST_END;
        end else begin
            if (apb_wr) begin
                if (paddr == `OFS_MODE_ENTRY)
                    mode_entry_q <= pwdata[15:0];
                else if (paddr == `OFS_DATA_CTL)
                    data_ctl_q <= pwdata[7:0];
                else if (paddr == `OFS_PE_MODE_CTL)
                    pe_mode_q <= pwdata[7:0];
                else if (paddr == `OFS_WB_ZERO)
                    wb_zero_q <= pwdata[15:0];
                else if (paddr == `OFS_WB_ONE)
                    wb_one_q <= pwdata[15:0];
                else if (paddr == `OFS_WB_HIGH)
                    wb_high_q <= pwdata[15:0];
                else if (paddr == `OFS_WB_LOW)
                    wb_low_q <= pwdata[15:0];
            end
            // Reject reasons are sticky; a new event beats the clear
            if (apb_wr && paddr == `OFS_REJECT)
                reject_q <= (reject_q & ~pwdata[5:0]) |
                            (req_valid ? why : 6'h00);
            else if (req_valid)
                reject_q <= reject_q | why;
            if (cmd_write && cmd_known && cmd_block)
                reject_q[`RJ_CMD] <= 1'b1;
            // Window bounds are latched from the buffers at issue
            // Buffers may be rewritten while busy; the staged copy
            // keeps the bounds that were issued
            if (cmd_write && cmd_known && !cmd_block) begin
                cmd_busy_q <= 1'b1;
                cmd_cnt_q  <= `CMD_CYCLES;
                cmd_swap_q <= (pwdata[7:0] == `CMD_STARTUP_PROG);
                if (variant_two) begin
                    stage_start_q <= wb_high_q[11:0];
                    stage_end_q   <= wb_low_q[11:0];
                end else begin
                    stage_start_q <= {2'b00, wb_zero_q[9:0]};
                    stage_end_q   <= {2'b00, wb_one_q[9:0]};
                end
            // Count down the busy time; the commit edge drops busy
            end else if (cmd_busy_q) begin
                cmd_cnt_q <= cmd_cnt_q - 4'h1;
                if (cmd_done)
                    cmd_busy_q <= 1'b0;
            end
        end
    end

    // =================================================================
    // Extra-area storage survives presetn; only power-on clears it.
    // Each field commits in one edge, so a reset mid-command leaves
    // the old value whole.
    // The presetn term stops a commit in a cycle in which the volatile
    // side is already held in reset.
    always @(posedge pclk or negedge nv_resetn) begin
        if (!nv_resetn) begin
            win_start_q <= `WIN_RST_START;
            win_end_q   <= `WIN_RST_END;
            nv_swap_q   <= 1'b0;
        end else if (cmd_done && presetn) begin
            if (cmd_swap_q)
                nv_swap_q <= ~nv_swap_q;
            else begin
                win_start_q <= stage_start_q;
                win_end_q   <= stage_end_q;
            end
        end
    end

    // Boot area is sampled once after reset release, not live, so a
    // swap only takes effect at the next reset
    // Trade-off: one extra flop keeps the boot choice steady while the
    // stored flag toggles during a running update
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_taken_q   <= 1'b0;
            boot_alternate <= 1'b0;
        end else if (!boot_taken_q) begin
            boot_taken_q   <= 1'b1;
            boot_alternate <= nv_swap_q;
        end
    end

    // =================================================================
    // Read data, registered at the setup phase
    // The command register and unmapped offsets read back zero
    always @* begin
        rd_mux = 32'h0000_0000;
        if (paddr == `OFS_MODE_ENTRY)
            rd_mux = {16'h0000, mode_entry_q};
        else if (paddr == `OFS_DATA_CTL)
            rd_mux = {24'h000000, data_ctl_q};
        else if (paddr == `OFS_PE_MODE_CTL)
            rd_mux = {24'h000000, pe_mode_q};
        else if (paddr == `OFS_WB_ZERO)
            rd_mux = {16'h0000, wb_zero_q};
        else if (paddr == `OFS_WB_ONE)
            rd_mux = {16'h0000, wb_one_q};
        else if (paddr == `OFS_WB_HIGH)
            rd_mux = {16'h0000, wb_high_q};
        else if (paddr == `OFS_WB_LOW)
            rd_mux = {16'h0000, wb_low_q};
        // Status bits are live; reading never clears anything
        else if (paddr == `OFS_STATUS)
            rd_mux = {26'h0, access_disable, pe_mode, nv_swap_q,
                      boot_alternate, cmd_swap_q, cmd_busy_q};
        else if (paddr == `OFS_WINDOW)
            rd_mux = {4'h0, win_end_q, 4'h0, win_start_q};
        else if (paddr == `OFS_REJECT)
            rd_mux = {26'h0, reject_q};
    end

    // Loaded only in a read setup cycle, so prdata stands until the
    // next read starts
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rdata_q <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            rdata_q <= rd_mux;
    end

endmodule

// [tb/flash_guard_properties.sv]
`timescale 1ns/100ps
`include "flash_guard_map.vh"
module flash_guard_checker (
    input wire        pclk,
    input wire        presetn,
    input wire        nv_resetn,
    input wire        variant_two,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [5:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        req_valid,
    input wire [1:0]  req_op,
    input wire        req_data_area,
    input wire [21:0] req_addr,
    input wire        req_grant,
    input wire        req_reject,
    input wire        boot_alternate
);
    reg [15:0] mode_q;
    reg [7:0]  dctl_q;
    reg [7:0]  pe_q;
    // ================================================================
    // Shadow of the guard registers, so the rules can be judged at ports
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= `MODE_READ;
            dctl_q <= `DATA_CTL_RST;
            pe_q   <= `PE_MODE_RST;
        end else if (psel && penable && pwrite && pready) begin
            case (paddr)
                `OFS_MODE_ENTRY:  mode_q <= pwdata[15:0];
                `OFS_DATA_CTL:    dctl_q <= pwdata[7:0];
                `OFS_PE_MODE_CTL: pe_q   <= pwdata[7:0];
                default: ;
            endcase
        end
    end
    // ================================================================
    // Request answers
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_grant; ##1 req_grant; endsequence
    sequence s_reject; ##1 req_reject; endsequence
    sequence s_user_pe;
        req_valid && !req_data_area && req_op != `OP_READ;
    endsequence
    property p_read_mode;
        req_valid && req_op != `OP_READ && mode_q == 16'h0000 |-> s_reject;
    endproperty
    property p_access_disable;
        req_valid && mode_q == 16'h0000 && dctl_q == 8'h00 &&
            (req_data_area || req_op != `OP_READ) |-> s_reject;
    endproperty
    property p_user_pe_dis;
        s_user_pe ##0 pe_q[`BIT_USER_PE_DIS] |-> s_reject;
    endproperty
    property p_data_en;
        req_valid && req_data_area && !dctl_q[`BIT_DATA_EN] |-> s_reject;
    endproperty
    property p_user_read;
        req_valid && !req_data_area && req_op == `OP_READ |-> s_grant;
    endproperty
    property p_one_answer; req_valid |=> req_grant ^ req_reject; endproperty
    property p_no_spurious;
        !req_valid |=> !req_grant && !req_reject;
    endproperty
    // Boot choice may only move on the first edge after a reset
    property p_boot_hold; $past(presetn, 2) |-> $stable(boot_alternate);
    endproperty
    property p_slverr; psel && penable && paddr > 6'h28 |-> pslverr;
    endproperty
    a_read_mode: assert property (p_read_mode)
        else $error("program or erase granted in read mode");
    a_access_disable: assert property (p_access_disable)
        else $error("access granted in access-disable mode");
    a_user_pe_dis: assert property (p_user_pe_dis)
        else $error("user program or erase granted while disabled");
    a_data_en: assert property (p_data_en)
        else $error("data area access granted while disabled");
    a_user_read: assert property (p_user_read)
        else $error("user area read was not granted");
    a_one_answer: assert property (p_one_answer)
        else $error("request without exactly one answer");
    a_no_spurious: assert property (p_no_spurious)
        else $error("answer without a request");
    a_boot_hold: assert property (p_boot_hold)
        else $error("boot selection moved outside reset");
    a_slverr: assert property (p_slverr)
        else $error("unmapped access without error response");
endmodule
bind flash_program_erase_guard flash_guard_checker i_chk (
    .pclk(pclk), .presetn(presetn), .nv_resetn(nv_resetn),
    .variant_two(variant_two), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
    .req_op(req_op), .req_data_area(req_data_area),
    .req_addr(req_addr), .req_grant(req_grant),
    .req_reject(req_reject), .boot_alternate(boot_alternate));

// [tb/flash_program_erase_guard_tb.sv]
`timescale 1ns/100ps
`include "flash_guard_map.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module flash_program_erase_guard_tb;
    reg        pclk, presetn, nv_resetn, variant_two, psel, penable, pwrite;
    reg [5:0]  paddr;
    reg [31:0] pwdata, rdata;
    reg        req_valid, req_data_area, rerr;
    reg [1:0]  req_op;
    reg [21:0] req_addr;
    wire [31:0] prdata;
    wire       pready, pslverr, req_grant, req_reject, boot_alternate;
    int        n_fail, checked, cycles, i;
    flash_program_erase_guard i_dut (
        .pclk(pclk), .presetn(presetn), .nv_resetn(nv_resetn),
        .variant_two(variant_two), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
        .req_op(req_op), .req_data_area(req_data_area),
        .req_addr(req_addr), .req_grant(req_grant),
        .req_reject(req_reject), .boot_alternate(boot_alternate));
    // ================================================================
    // Clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            end_of_test;
        end
    end
    // ================================================================
    // Bus and request tasks
    task end_of_test;
        if (n_fail == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Holds the request until pready is seen; no fixed wait assumed
    task apb(input [5:0] a, input w, input [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input [5:0] a, input [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task rd(input [5:0] a, input [31:0] e);
        apb(a, 1'b0, 32'h0);
        `CHK("prdata", e, rdata)
        `CHK("pslverr", a > 6'h28, rerr)
    endtask
    // Answer is a one-cycle pulse in the cycle after the request
    task rq(input [1:0] op, input da, input [21:0] ad, input g);
        @(posedge pclk);
        req_valid <= 1'b1; req_op <= op; req_data_area <= da; req_addr <= ad;
        @(posedge pclk);
        req_valid <= 1'b0;
        #1;
        `CHK("req_grant", g, req_grant)
        `CHK("req_reject", !g, req_reject)
    endtask
    // Command runs four busy cycles before it commits
    task cmd(input [7:0] c);
        wr(`OFS_COMMAND, {24'h0, c});
        repeat (6) @(posedge pclk);
    endtask
    task rst_pulse;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        #1;
    endtask
    // ================================================================
    // Main sequence
    initial begin
        {presetn, nv_resetn, variant_two, psel, penable, pwrite} = 6'h00;
        {paddr, pwdata, req_valid, req_op, req_data_area, req_addr} = 0;
        n_fail = 0;
        checked = 0;
        cycles = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        nv_resetn <= 1'b1;
        rd(`OFS_MODE_ENTRY, 32'h0);
        rd(`OFS_DATA_CTL, 32'h1);
        rd(`OFS_PE_MODE_CTL, 32'h0);
        rd(`OFS_WINDOW, 32'h0fff0000);
        rd(6'h2c, 32'h0);
        rq(`OP_PROGRAM, 1'b0, 22'h0, 1'b0);
        rq(`OP_ERASE, 1'b1, 22'h0, 1'b0);
        rq(`OP_READ, 1'b1, 22'h0, 1'b1);
        wr(`OFS_MODE_ENTRY, 32'h1);
        rq(`OP_ERASE, 1'b1, 22'h0, 1'b1);
        wr(`OFS_PE_MODE_CTL, 32'h8);
        rq(`OP_ERASE, 1'b0, 22'h0, 1'b0);
        rq(`OP_PROGRAM, 1'b1, 22'h0, 1'b1);
        wr(`OFS_PE_MODE_CTL, 32'h0);
        wr(`OFS_WB_ZERO, 32'h4);
        wr(`OFS_WB_ONE, 32'h8);
        cmd(`CMD_WINDOW_PROG);
        rd(`OFS_WINDOW, 32'h00080004);
        for (i = 3; i < 9; i++)
            rq(`OP_PROGRAM, 1'b0, {i[11:0], 10'h0}, i >= 4 && i < 8);
        @(posedge pclk);
        variant_two <= 1'b1;
        wr(`OFS_WB_HIGH, 32'h100);
        wr(`OFS_WB_LOW, 32'h104);
        cmd(`CMD_WINDOW_PROG);
        rd(`OFS_WINDOW, 32'h01040100);
        rq(`OP_ERASE, 1'b0, {12'h103, 10'h0}, 1'b1);
        rq(`OP_ERASE, 1'b0, {12'h104, 10'h0}, 1'b0);
        wr(`OFS_REJECT, 32'h3f);
        wr(`OFS_DATA_CTL, 32'h0);
        rq(`OP_READ, 1'b1, 22'h0, 1'b0);
        cmd(`CMD_STARTUP_PROG);
        rd(`OFS_REJECT, 32'h30);
        wr(`OFS_MODE_ENTRY, 32'h0);
        rq(`OP_PROGRAM, 1'b0, {12'h100, 10'h0}, 1'b0);
        rq(`OP_READ, 1'b1, 22'h0, 1'b0);
        rq(`OP_READ, 1'b0, 22'h0, 1'b1);
        wr(`OFS_MODE_ENTRY, 32'h1);
        wr(`OFS_DATA_CTL, 32'h1);
        cmd(`CMD_STARTUP_PROG);
        `CHK("boot_alternate", 1'b0, boot_alternate)
        rst_pulse;
        `CHK("boot_alternate", 1'b1, boot_alternate)
        rd(`OFS_WINDOW, 32'h01040100);
        rd(`OFS_STATUS, 32'h0000000c);
        wr(`OFS_MODE_ENTRY, 32'h1);
        wr(`OFS_COMMAND, {24'h0, `CMD_STARTUP_PROG});
        repeat (2) @(posedge pclk);
        rst_pulse;
        `CHK("boot_alternate", 1'b1, boot_alternate)
        end_of_test;
    end
endmodule
